// ===== pcs_cpu_model.sv
// cpu-side model that issues peripheral bus reads and times their completion
`timescale 1ns/1ps
`default_nettype none
module pcs_cpu_model (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_go,
   input wire logic i_pb_ack,
   output logic o_pb_req,
   output logic [7:0] o_lat
);
   // ---------------------------------------------------------------
   // access request
   // ---------------------------------------------------------------
   // request held until pb edge ack
   // no abort path: a real core cannot cancel a stalled load either
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pb_req <= 1'b0;
         o_lat <= 8'h00;
      end else if (o_pb_req) begin
         o_lat <= o_lat + 8'h01;
         if (i_pb_ack) begin
            o_pb_req <= 1'b0;
         end
      end else if (i_go) begin
         o_pb_req <= 1'b1;
         o_lat <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== pcs_divider.sv
// peripheral bus clock enable divider
`timescale 1ns/1ps
`default_nettype none
module pcs_divider
   import pcs_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [1:0] i_sel,
   output logic o_pb_tick
);
   logic [2:0] cnt_r;
   logic [1:0] sel_r;
   logic [2:0] term;
   function automatic logic [2:0] div_term(input logic [1:0] s);
      case (s)
         2'b00: div_term = 3'h0;
         2'b01: div_term = 3'h1;
         2'b10: div_term = 3'h3;
         default: div_term = 3'h7;
      endcase
   endfunction
   assign term = div_term(sel_r);
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_r <= 3'h0;
         sel_r <= 2'b00;
      end else if (cnt_r >= term) begin
         cnt_r <= 3'h0;
         sel_r <= i_sel;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   assign o_pb_tick = (cnt_r >= term);
   // select 3 spaces ticks by eight
   tick_space_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (o_pb_tick && sel_r == 2'b11 && i_sel == 2'b11 && term == 3'h7) |=> !o_pb_tick [*7])
      else $error("divided tick spacing wrong");
   tick_full_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (sel_r == 2'b00) |-> o_pb_tick)
      else $error("full rate tick missing");
endmodule
`default_nettype wire

// ===== pcs_pkg.sv
// types shared by the clock scaler design
package pcs_pkg;
   typedef enum logic [2:0] {
      PCS_RUN = 3'b001,
      PCS_IDLE = 3'b010,
      PCS_WAKE = 3'b100
   } pcs_state_e;
   typedef struct packed {
      logic [1:0] pb_divider_select;
      logic [2:0] pll_multiplier;
      logic [2:0] fast_rc_postscale;
      logic [1:0] clk_source;
      logic sleep_select;
   } pcs_osc_s;
endpackage

// ===== pcs_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_OFF_OSC_CONTROL 4'h0
`define PCS_OFF_UNLOCK_KEY 4'h4
`define PCS_OFF_RESET_CONTROL 4'h8
`define PCS_OFF_PERIPH_CTRL 4'hC
`define PCS_KEY1 32'hAA996655
`define PCS_KEY2 32'h556699AA
`define PCS_PB_DIVIDER_SELECT_LSB 19
`define PCS_PB_DIVIDER_SELECT_MSB 20
`define PCS_PLLMUL_LSB 16
`define PCS_PLLMUL_MSB 18
`define PCS_FRCDIV_LSB 24
`define PCS_FRCDIV_MSB 26
`define PCS_SRC_LSB 12
`define PCS_SRC_MSB 13
`define PCS_SLEEP_BIT 4
`define PCS_IDLE_FLAG_BIT 2
`define PCS_OSC_RESET 32'h0000_0000
`define PCS_OSC_WMASK 32'h071F_3010
`define PCS_START_NS 1000
`define PCS_START_CYC ((`PCS_START_NS + 7) / 8)
`endif

// ===== pcs_top.sv
// peripheral bus clock scaler and idle control with axi4-lite registers
// ---------------------------------------------------------------
// Summary of operation
// - pb clock divided by field 20:19
// - zero gives 1:1, three gives 1:8
// - all pb blocks change together
// - system blocks stay on system clock
// - peripheral read completes on next pb edge
// - two keys unlock, bad key relocks
// - idle halts cpu, source keeps running
// - stop-in-idle peripherals halt in idle
// - four idle variants by clock source; here idle is alike for all, source 00 only adds a wake start-up hold
// - pll multiplier lowerable in idle
// - fast rc divided by field 26:24
// - wait with sleep clear enters idle
// - wake only above cpu priority
// - any reset leaves idle
// - watchdog timeout leaves idle
// - startup delay for restarted crystal/pll
// - idle flag set on wake
// - priority zero never wakes
// - coincident interrupt waits for idle entry
// ---------------------------------------------------------------
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_top
   import pcs_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [3:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [3:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_wait_exec,
   input wire logic i_irq_valid,
   input wire logic [2:0] i_irq_prio,
   input wire logic [2:0] i_cpu_prio,
   input wire logic i_wdt_timeout,
   input wire logic i_src_ready,
   input wire logic i_pb_req,
   output logic o_pb_ack,
   output logic o_cpu_halt,
   output logic o_pb_tick,
   output logic [7:0] o_periph_run,
   output logic [1:0] o_clk_source,
   output logic [2:0] o_pll_multiplier,
   output logic [2:0] o_fast_rc_postscale,
   output logic o_src_switching
);
   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   pcs_osc_s osc_r;
   logic [7:0] stop_in_idle_r;
   logic idle_flag_r;
   logic [1:0] key_st_r;
   logic aw_hold_r, w_hold_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_wr, do_rd;
   logic unlocked;
   logic [31:0] osc_word;
   logic [31:0] wmerged;
   pcs_state_e st_r;
   logic [9:0] start_cnt_r;
   logic wake_evt, wait_sync1_r;
   logic pb_tick;

   function automatic logic [31:0] pack_osc(input pcs_osc_s o);
      logic [31:0] v;
      v = 32'h0;
      v[`PCS_PB_DIVIDER_SELECT_MSB:`PCS_PB_DIVIDER_SELECT_LSB] = o.pb_divider_select;
      v[`PCS_PLLMUL_MSB:`PCS_PLLMUL_LSB] = o.pll_multiplier;
      v[`PCS_FRCDIV_MSB:`PCS_FRCDIV_LSB] = o.fast_rc_postscale;
      v[`PCS_SRC_MSB:`PCS_SRC_LSB] = o.clk_source;
      v[`PCS_SLEEP_BIT] = o.sleep_select;
      pack_osc = v;
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      strb_merge = r;
   endfunction

   assign osc_word = pack_osc(osc_r);
   assign wmerged = strb_merge(osc_word, w_data_r, w_strb_r);
   assign do_wr = aw_hold_r && w_hold_r && !o_bvalid;
   assign do_rd = i_arvalid && o_arready;
   assign unlocked = (key_st_r == 2'd2);

   // write channels taken independently, response after both
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         o_awready <= 1'b1;
         o_wready <= 1'b1;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= i_awaddr;
            o_awready <= 1'b0;
         end else if (do_wr) begin
            aw_hold_r <= 1'b0;
            o_awready <= 1'b1;
         end
         if (i_wvalid && o_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= i_wdata;
            w_strb_r <= i_wstrb;
            o_wready <= 1'b0;
         end else if (do_wr) begin
            w_hold_r <= 1'b0;
            o_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= 2'b00;
      end else if (do_wr) begin
         o_bvalid <= 1'b1;
         o_bresp <= (aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // key sequence, any other word relocks
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         key_st_r <= 2'd0;
      end else if (do_wr && aw_addr_r == `PCS_OFF_UNLOCK_KEY) begin
         if (key_st_r == 2'd0 && w_data_r == `PCS_KEY1) begin
            key_st_r <= 2'd1;
         end else if (key_st_r == 2'd1 && w_data_r == `PCS_KEY2) begin
            key_st_r <= 2'd2;
         end else begin
            key_st_r <= 2'd0;
         end
      end
   end

   // control fields only change when unlocked
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         osc_r <= pcs_osc_s'(11'h0);
      end else if (do_wr && aw_addr_r == `PCS_OFF_OSC_CONTROL && unlocked) begin
         osc_r.pll_multiplier <= wmerged[`PCS_PLLMUL_MSB:`PCS_PLLMUL_LSB];
         osc_r.pb_divider_select <= wmerged[`PCS_PB_DIVIDER_SELECT_MSB:`PCS_PB_DIVIDER_SELECT_LSB];
         osc_r.fast_rc_postscale <= wmerged[`PCS_FRCDIV_MSB:`PCS_FRCDIV_LSB];
         osc_r.clk_source <= wmerged[`PCS_SRC_MSB:`PCS_SRC_LSB];
         osc_r.sleep_select <= wmerged[`PCS_SLEEP_BIT];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         stop_in_idle_r <= 8'h00;
      end else if (do_wr && aw_addr_r == `PCS_OFF_PERIPH_CTRL && w_strb_r[0]) begin
         stop_in_idle_r <= w_data_r[7:0];
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= 2'b00;
      end else if (do_rd) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rresp <= 2'b00;
         case (i_araddr)
            `PCS_OFF_OSC_CONTROL: o_rdata <= osc_word;
            `PCS_OFF_UNLOCK_KEY: o_rdata <= 32'h0;
            `PCS_OFF_RESET_CONTROL: o_rdata <= {29'h0, idle_flag_r, 2'b00};
            `PCS_OFF_PERIPH_CTRL: o_rdata <= {24'h0, stop_in_idle_r};
            default: begin
               o_rdata <= 32'h0;
               o_rresp <= 2'b10;
            end
         endcase
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // peripheral bus clock
   // ---------------------------------------------------------------
   // one tick feeds every pb peripheral
   pcs_divider u_div (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_sel(osc_r.pb_divider_select),
      .o_pb_tick(pb_tick)
   );

   // system blocks take i_mclk, not the tick
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pb_tick <= 1'b0;
      end else begin
         o_pb_tick <= pb_tick;
      end
   end

   // peripheral access answered on pb edge
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_pb_ack <= 1'b0;
      end else begin
         o_pb_ack <= i_pb_req && pb_tick && !o_pb_ack;
      end
   end

   // ---------------------------------------------------------------
   // idle state machine
   // ---------------------------------------------------------------
   // wait pulse is same-clock logic; a pipeline stage gives the entry slot
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         wait_sync1_r <= 1'b0;
      end else begin
         wait_sync1_r <= i_wait_exec && !osc_r.sleep_select;
      end
   end

   assign wake_evt = (i_irq_valid && i_irq_prio != 3'h0 && i_irq_prio > i_cpu_prio)
                     || i_wdt_timeout;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         st_r <= PCS_RUN;
         start_cnt_r <= 10'h0;
      end else begin
         case (st_r)
            PCS_RUN: begin
               if (wait_sync1_r) begin
                  st_r <= PCS_IDLE;
               end
            end
            PCS_IDLE: begin
               // wake considered only once inside idle
               if (wake_evt) begin
                  st_r <= PCS_WAKE;
                  start_cnt_r <= 10'(`PCS_START_CYC);
               end
            end
            PCS_WAKE: begin
               if (!o_src_switching || start_cnt_r == 10'h0) begin
                  st_r <= PCS_RUN;
               end else begin
                  start_cnt_r <= start_cnt_r - 10'h1;
               end
            end
            default: st_r <= PCS_RUN;
         endcase
      end
   end

   // restarted crystal or pll source flagged
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_src_switching <= 1'b0;
      end else begin
         o_src_switching <= !i_src_ready && (osc_r.clk_source == 2'b00);
      end
   end

   // flag set on wake, software clears
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         idle_flag_r <= 1'b0;
      end else if (st_r == PCS_IDLE && wake_evt) begin
         idle_flag_r <= 1'b1;
      end else if (do_wr && aw_addr_r == `PCS_OFF_RESET_CONTROL && w_strb_r[0]) begin
         idle_flag_r <= w_data_r[`PCS_IDLE_FLAG_BIT];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         o_cpu_halt <= 1'b0;
         o_periph_run <= 8'hFF;
         o_clk_source <= 2'b00;
         o_pll_multiplier <= 3'h0;
         o_fast_rc_postscale <= 3'h0;
      end else begin
         o_cpu_halt <= (st_r != PCS_RUN) || wait_sync1_r;
         o_periph_run <= (st_r == PCS_IDLE) ? ~stop_in_idle_r : 8'hFF;
         o_clk_source <= osc_r.clk_source;
         o_pll_multiplier <= osc_r.pll_multiplier;
         o_fast_rc_postscale <= osc_r.fast_rc_postscale;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   idle_entry_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_RUN && wait_sync1_r) |=> st_r == PCS_IDLE)
      else $error("idle not entered on wait");
   low_prio_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_IDLE && !i_wdt_timeout && (!i_irq_valid || i_irq_prio <= i_cpu_prio))
      |=> st_r == PCS_IDLE)
      else $error("low priority woke cpu");
   zero_prio_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_IDLE && !i_wdt_timeout && i_irq_prio == 3'h0) |=> st_r == PCS_IDLE)
      else $error("priority zero woke cpu");
   wdt_wake_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_IDLE && i_wdt_timeout) |=> st_r == PCS_WAKE ##1 idle_flag_r)
      else $error("watchdog did not wake");
   halt_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_IDLE) |=> o_cpu_halt)
      else $error("cpu not halted in idle");
   reset_run_a: assert property (@(posedge i_mclk)
      i_rst |=> st_r == PCS_RUN)
      else $error("reset left idle");
   key_lock_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (do_wr && aw_addr_r == `PCS_OFF_OSC_CONTROL && !unlocked) |=> $stable(osc_r))
      else $error("locked write changed control");
   periph_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (st_r == PCS_IDLE) ##1 (st_r == PCS_IDLE) |-> o_periph_run == ~stop_in_idle_r)
      else $error("stop in idle gating wrong");
   pb_ack_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_pb_ack |-> $past(pb_tick))
      else $error("pb ack off tick");
   idle_cov: cover property (@(posedge i_mclk) st_r == PCS_IDLE ##1 st_r == PCS_WAKE);
   unlock_cov: cover property (@(posedge i_mclk) unlocked && do_wr);
   div8_cov: cover property (@(posedge i_mclk) osc_r.pb_divider_select == 2'b11 && pb_tick);
endmodule
`default_nettype wire

// ===== tb.sv
// testbench for the clock scaler: register access, pb divider and idle control
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic wait_exec = 1'b0, irq_valid = 1'b0, wdt = 1'b0, src_ready = 1'b1, go = 1'b0;
   logic [2:0] irq_prio = 3'h0, cpu_prio = 3'h0;
   logic awready, wready, bvalid, arready, rvalid, cpu_halt, pb_tick, src_sw, pb_req, pb_ack;
   logic [1:0] bresp, rresp, clk_source, r;
   logic [31:0] rdata, d, v;
   logic [7:0] periph_run, lat;
   logic [2:0] pll_mult, rc_post;
   int miscompares = 0;
   int n_tests = 0;
   int p;
   always #4 clk = ~clk;
   pcs_top DUT (.i_mclk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_wait_exec(wait_exec),
      .i_irq_valid(irq_valid), .i_irq_prio(irq_prio), .i_cpu_prio(cpu_prio), .i_wdt_timeout(wdt),
      .i_src_ready(src_ready), .i_pb_req(pb_req), .o_pb_ack(pb_ack), .o_cpu_halt(cpu_halt),
      .o_pb_tick(pb_tick), .o_periph_run(periph_run), .o_clk_source(clk_source),
      .o_pll_multiplier(pll_mult), .o_fast_rc_postscale(rc_post), .o_src_switching(src_sw));
   pcs_cpu_model cpu (.i_mclk(clk), .i_rst(rst), .i_go(go), .i_pb_ack(pb_ack), .o_pb_req(pb_req), .o_lat(lat));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic tmo();
      miscompares++;
      $display("ERROR wait expected response seen none");
      test_done();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // write address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] dat);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
      if (n >= 100) tmo();
   endtask
   task automatic axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rs);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      dat = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge clk);
      if (n >= 100) tmo();
   endtask
   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
      axi_rd(a, d, r);
      chk(nm, e, d);
   endtask
   task automatic unlock();
      axi_wr(`PCS_OFF_UNLOCK_KEY, `PCS_KEY1);
      axi_wr(`PCS_OFF_UNLOCK_KEY, `PCS_KEY2);
   endtask
   task automatic wait_halt(input logic want);
      int n;
      n = 0;
      while (cpu_halt !== want && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) tmo();
   endtask
   task automatic pulse_wait();
      wait_exec <= 1'b1;
      cyc(1);
      wait_exec <= 1'b0;
   endtask
   // cycles between two pb ticks; first tick hunted for under a bound
   task automatic tick_period(output int pp);
      int n;
      n = 0;
      while (pb_tick !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) tmo();
      pp = 0;
      do begin
         @(posedge clk);
         pp++;
      end while (pb_tick !== 1'b1 && pp < 50);
   endtask
   function automatic logic [31:0] osc(input logic [1:0] dv, input logic [2:0] pl, input logic [2:0] rc,
      input logic [1:0] sr, input logic sl);
      osc = {5'h00, rc, 3'h0, dv, pl, 2'h0, sr, 7'h00, sl, 4'h0};
   endfunction
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(6);
      rst <= 1'b0;
      cyc(1);
      chk("periph_run", 32'hFF, {24'h0, periph_run});
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h0, 3'h0, 2'h0, 1'b0));
      chk("wr_resp", 32'h0, {30'h0, r});
      rd_chk("osc_locked", `PCS_OFF_OSC_CONTROL, 32'h0);
      rd_chk("reset_ctl", `PCS_OFF_RESET_CONTROL, 32'h0);
      rd_chk("key_reg", `PCS_OFF_UNLOCK_KEY, 32'h0);
      axi_rd(4'h2, d, r);
      chk("unmapped_resp", 32'h2, {30'h0, r});
      // no pb access in flight while the ratio moves
      unlock();
      for (int i = 0; i < 4; i++) begin
         v = osc(i[1:0], 3'(i + 1), 3'(7 - i), 2'(3 - i), 1'b0);
         axi_wr(`PCS_OFF_OSC_CONTROL, v);
         rd_chk("osc", `PCS_OFF_OSC_CONTROL, v & `PCS_OSC_WMASK);
         cyc(2);
         chk("clk_source", 32'(3 - i), {30'h0, clk_source});
         chk("pll_mult", 32'(i + 1), {29'h0, pll_mult});
         chk("rc_post", 32'(7 - i), {29'h0, rc_post});
         tick_period(p);
         tick_period(p);
         chk("pb_period", 32'(1 << i), 32'(p));
         go <= 1'b1;
         cyc(1);
         go <= 1'b0;
         cyc(12);
         chk("pb_read_done", 32'h0, {31'h0, pb_req});
         chk("pb_lat_ok", 32'h1, {31'h0, (lat >= 8'h01 && lat <= 8'((1 << i) + 1))});
      end
      axi_wr(`PCS_OFF_UNLOCK_KEY, 32'h0);
      axi_wr(`PCS_OFF_OSC_CONTROL, 32'h0);
      rd_chk("osc_relock", `PCS_OFF_OSC_CONTROL, v & `PCS_OSC_WMASK);
      unlock();
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h4, 3'h4, 2'h1, 1'b0));
      src_ready <= 1'b0;
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h4, 3'h4, 2'h0, 1'b0));
      cyc(2);
      chk("src_switching", 32'h1, {31'h0, src_sw});
      src_ready <= 1'b1;
      cyc(2);
      chk("src_settled", 32'h0, {31'h0, src_sw});
      axi_wr(`PCS_OFF_PERIPH_CTRL, 32'h0F);
      pulse_wait();
      wait_halt(1'b1);
      cyc(3);
      chk("periph_idle", 32'hF0, {24'h0, periph_run});
      // multiplier lowered while the cpu sits in idle
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h2, 3'h4, 2'h0, 1'b0));
      cyc(2);
      chk("pll_idle", 32'h2, {29'h0, pll_mult});
      tick_period(p);
      chk("pb_in_idle", 32'h8, 32'(p));
      irq_valid <= 1'b1;
      irq_prio <= 3'h2;
      cpu_prio <= 3'h3;
      cyc(20);
      chk("halt_low_prio", 32'h1, {31'h0, cpu_halt});
      irq_prio <= 3'h0;
      cpu_prio <= 3'h0;
      cyc(20);
      chk("halt_prio_zero", 32'h1, {31'h0, cpu_halt});
      irq_prio <= 3'h5;
      cpu_prio <= 3'h3;
      wait_halt(1'b0);
      irq_valid <= 1'b0;
      cyc(2);
      chk("periph_awake", 32'hFF, {24'h0, periph_run});
      rd_chk("idle_flag", `PCS_OFF_RESET_CONTROL, 32'h4);
      axi_wr(`PCS_OFF_RESET_CONTROL, 32'h0);
      rd_chk("idle_flag_clr", `PCS_OFF_RESET_CONTROL, 32'h0);
      pulse_wait();
      wait_halt(1'b1);
      wdt <= 1'b1;
      cyc(1);
      wdt <= 1'b0;
      wait_halt(1'b0);
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h4, 3'h4, 2'h0, 1'b1));
      pulse_wait();
      cyc(10);
      chk("no_idle_sleepsel", 32'h0, {31'h0, cpu_halt});
      axi_wr(`PCS_OFF_OSC_CONTROL, osc(2'h3, 3'h4, 3'h4, 2'h0, 1'b0));
      irq_valid <= 1'b1;
      wait_exec <= 1'b1;
      cyc(1);
      wait_exec <= 1'b0;
      wait_halt(1'b1);
      wait_halt(1'b0);
      irq_valid <= 1'b0;
      // wake with crystal source not ready: cpu held through start-up count
      src_ready <= 1'b0;
      pulse_wait();
      wait_halt(1'b1);
      wdt <= 1'b1;
      cyc(1);
      wdt <= 1'b0;
      cyc(60);
      chk("startup_hold", 32'h1, {31'h0, cpu_halt});
      wait_halt(1'b0);
      src_ready <= 1'b1;
      pulse_wait();
      wait_halt(1'b1);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      chk("halt_after_rst", 32'h0, {31'h0, cpu_halt});
      rd_chk("osc_after_rst", `PCS_OFF_OSC_CONTROL, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
